// ==== design/dtcp_map.svh ====
// register map, field positions, reset values and timing counts of the timer pair
// assumes byte-addressed avalon access, one 32-bit word per register
`ifndef DTCP_MAP_SVH
`define DTCP_MAP_SVH

// --------------------------------------------------------------------------
// register indices (byte address is four times the index)
// --------------------------------------------------------------------------
`define DTCP_IDX_CONTROL 8'h88
`define DTCP_IDX_MODE 8'h89
`define DTCP_IDX_LOW0 8'h8a
`define DTCP_IDX_LOW1 8'h8b
`define DTCP_IDX_HIGH0 8'h8c
`define DTCP_IDX_HIGH1 8'h8d
`define DTCP_IDX_PRESCALE 8'h8e
`define DTCP_IDX_PORT2 8'hb5

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define DTCP_CTL_OVF1 7
`define DTCP_CTL_RUN1 6
`define DTCP_CTL_OVF0 5
`define DTCP_CTL_RUN0 4
`define DTCP_MOD_GATE1 7
`define DTCP_MOD_SEL1 6
`define DTCP_MOD_GATE0 3
`define DTCP_MOD_SEL0 2
`define DTCP_CKC_CLK1 4
`define DTCP_CKC_CLK0 3
`define DTCP_P2_OE1 3
`define DTCP_P2_OE0 2

// --------------------------------------------------------------------------
// reset values and timing
// --------------------------------------------------------------------------
`define DTCP_RST_BYTE 8'h00
`define DTCP_PRESCALE_DIV 12

`endif

// ==== design/dtcp_pin_sync.sv ====
// two-flop synchroniser with falling-edge detector for external pins
// assumes asynchronous pins, one system clock
`timescale 1ns/1ps
module dtcp_pin_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic [WIDTH-1:0] pinAsync,
  // synchronised view
  output logic [WIDTH-1:0] pinLevel,
  output logic [WIDTH-1:0] pinFall
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] prev_ff;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("dtcp_pin_sync needs at least one pin");
    end
  endgenerate

  // RULE_21 - pins synchronised first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= pinAsync;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign pinLevel = sync_ff;
  // RULE_05 - high then low
  assign pinFall = prev_ff & ~sync_ff;

endmodule

// ==== design/dtcp_pkg.sv ====
// types shared by the timer pair, its pin source model and its checker
// assumes the map header is included wherever offsets are needed
package dtcp_pkg;

  typedef enum logic [1:0] {
    DTCP_MODE13,
    DTCP_MODE16,
    DTCP_RELOAD8,
    DTCP_SPLIT8
  } dtcp_mode_e;

  typedef struct packed {
    logic [1:0] countPin;
    logic [1:0] gatePin;
  } dtcp_pins_in_s;

  typedef struct packed {
    logic [1:0] countOut;
    logic [1:0] countOe_n;
  } dtcp_pins_out_s;

  typedef logic [7:0] dtcp_byte_t;

endpackage

// ==== design/dtcp_timer_pair.sv ====
// two 16-bit timer/counters with shared mode and control registers
// assumes an avalon-mm master on clk; pins arrive asynchronously
//
// Functional notes
// RULE_01 - each unit: high and low count bytes
// RULE_02 - select bits pick timer or counter
// RULE_03 - timer clock: divided by 12 or direct
// RULE_04 - counter mode counts count-pin falling edges
// RULE_05 - falling edge: high then low sample
// RULE_06 - toggle output inverts on each overflow
// RULE_07 - toggle output starts at logic 1
// RULE_08 - software keeps timer mode when toggling
// RULE_09 - software stops unit before byte access
// RULE_10 - gate bit adds gate pin condition
// RULE_11 - modes: 13-bit, 16-bit, 8-bit reload
// RULE_12 - unit 1 mode 11 holds count
// RULE_13 - unit 0 mode 11 splits bytes
// RULE_14 - run bit clear stops, keeps count
// RULE_15 - overflow flags: hardware set, ack clears
// RULE_16 - control register holds run and flags
// RULE_17 - 13-bit mode rolls at 1FFFH
// RULE_18 - 16-bit mode rolls at FFFFH
// RULE_19 - reload low byte from high byte
// RULE_20 - split high byte borrows unit 1 bits
// RULE_21 - count pins registered before edge detect
`timescale 1ns/1ps
`include "dtcp_map.svh"
module dtcp_timer_pair #(
  parameter int PRESCALE_DIV = `DTCP_PRESCALE_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // interrupt service entry, one pulse per unit
  input wire logic [1:0] isrEnter,
  // overflow flags towards interrupt controller
  output logic [1:0] overflowFlag,
  // pins
  input wire dtcp_pkg::dtcp_pins_in_s pinsIn,
  output dtcp_pkg::dtcp_pins_out_s pinsOut
);
  import dtcp_pkg::*;

  generate
    if (PRESCALE_DIV < 2 || PRESCALE_DIV > 255) begin : g_chk
      $error("PRESCALE_DIV must be 2 to 255");
    end
  endgenerate

  localparam logic [7:0] PRE_LAST = 8'(PRESCALE_DIV - 1);

  // --------------------------------------------------------------------------
  // count step
  // --------------------------------------------------------------------------
  // returns {overflow, high, low}
  function automatic logic [16:0] stepCount(input dtcp_mode_e m, input dtcp_byte_t h,
                                            input dtcp_byte_t l);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    logic [16:0] r;
    s13 = {1'b0, h, l[4:0]} + 14'h0001;
    s16 = {1'b0, h, l} + 17'h0_0001;
    s8 = {1'b0, l} + 9'h001;
    r = {1'b0, h, l};
    unique case (m)
      // RULE_17 - 13-bit rollover
      DTCP_MODE13: r = {s13[13], s13[12:5], l[7:5], s13[4:0]};
      // RULE_18 - 16-bit rollover
      DTCP_MODE16: r = s16;
      // RULE_19 - low byte reload
      DTCP_RELOAD8: r = {s8[8], h, (s8[8] ? h : s8[7:0])};
      DTCP_SPLIT8: r = {1'b0, h, l};
    endcase
    return r;
  endfunction

  function automatic logic [8:0] step8(input dtcp_byte_t v);
    return {1'b0, v} + 9'h001;
  endfunction

  // --------------------------------------------------------------------------
  // pins
  // --------------------------------------------------------------------------
  logic [1:0] countFall;
  logic [1:0] gateLevel;

  dtcp_pin_sync #(.WIDTH(2)) u_count_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinAsync(pinsIn.countPin),
    .pinLevel(),
    .pinFall(countFall)
  );

  dtcp_pin_sync #(.WIDTH(2)) u_gate_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinAsync(pinsIn.gatePin),
    .pinLevel(gateLevel),
    .pinFall()
  );

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0] pre_ff, nxt_pre;
  dtcp_byte_t ctl_ff, nxt_ctl;
  dtcp_byte_t mode_ff, nxt_mode;
  dtcp_byte_t ckc_ff, nxt_ckc;
  dtcp_byte_t p2_ff, nxt_p2;
  dtcp_byte_t low_ff [2];
  dtcp_byte_t nxt_low [2];
  dtcp_byte_t high_ff [2];
  dtcp_byte_t nxt_high [2];
  logic [1:0] tog_ff, nxt_tog;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  logic req;
  logic wrTake;
  logic [7:0] idx;
  dtcp_byte_t wByte;
  logic [31:0] rdMux;

  assign req = read | write;
  assign idx = address[9:2];
  assign wByte = writedata[7:0];
  // one wait state; write lands at the edge waitrequest is low
  assign wrTake = write & ack_ff & byteenable[0];
  assign waitrequest = req & ~ack_ff;
  assign readdata = rdata_ff;

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (idx)
      `DTCP_IDX_CONTROL: rdMux[7:0] = {ctl_ff[7:4], 4'h0};
      `DTCP_IDX_MODE: rdMux[7:0] = mode_ff;
      `DTCP_IDX_LOW0: rdMux[7:0] = low_ff[0];
      `DTCP_IDX_LOW1: rdMux[7:0] = low_ff[1];
      `DTCP_IDX_HIGH0: rdMux[7:0] = high_ff[0];
      `DTCP_IDX_HIGH1: rdMux[7:0] = high_ff[1];
      `DTCP_IDX_PRESCALE: rdMux[7:0] = ckc_ff & 8'h18;
      `DTCP_IDX_PORT2: rdMux[7:0] = p2_ff & 8'h0c;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_ack = req & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (read && !ack_ff) begin
      nxt_rdata = rdMux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------------------
  logic tickDiv;

  assign tickDiv = (pre_ff == PRE_LAST);

  always_comb begin
    nxt_pre = tickDiv ? 8'h00 : pre_ff + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 8'h00;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  // --------------------------------------------------------------------------
  // count enables
  // --------------------------------------------------------------------------
  dtcp_mode_e mode0, mode1;
  logic split;
  logic [1:0] gateBit, selBit, clkBit, runBit, srcTick, enable;
  logic timerTick0;

  assign mode0 = dtcp_mode_e'(mode_ff[1:0]);
  assign mode1 = dtcp_mode_e'(mode_ff[5:4]);
  assign split = (mode0 == DTCP_SPLIT8);
  assign gateBit = {mode_ff[`DTCP_MOD_GATE1], mode_ff[`DTCP_MOD_GATE0]};
  assign selBit = {mode_ff[`DTCP_MOD_SEL1], mode_ff[`DTCP_MOD_SEL0]};
  assign clkBit = {ckc_ff[`DTCP_CKC_CLK1], ckc_ff[`DTCP_CKC_CLK0]};
  // RULE_20 - unit 1 runs free of its run bit in split
  assign runBit = {ctl_ff[`DTCP_CTL_RUN1] | split, ctl_ff[`DTCP_CTL_RUN0]};
  // RULE_03 - divided or direct clock
  assign timerTick0 = clkBit[0] | tickDiv;

  always_comb begin
    for (int u = 0; u < 2; u++) begin
      // RULE_02 - timer or counter source
      // RULE_04 - pin falling edge in counter mode
      srcTick[u] = selBit[u] ? countFall[u] : (clkBit[u] | tickDiv);
      // RULE_10 - gate condition
      // RULE_14 - run bit enables counting
      enable[u] = runBit[u] & (~gateBit[u] | gateLevel[u]) & srcTick[u];
    end
  end

  // --------------------------------------------------------------------------
  // counters, flags, toggle outputs
  // --------------------------------------------------------------------------
  logic [16:0] step0, step1;
  logic [8:0] splitLow, splitHigh;
  logic [1:0] ovf, setFlag;

  always_comb begin
    step0 = stepCount(mode0, high_ff[0], low_ff[0]);
    step1 = stepCount(mode1, high_ff[1], low_ff[1]);
    splitLow = step8(low_ff[0]);
    splitHigh = step8(high_ff[0]);
    nxt_low = low_ff;
    nxt_high = high_ff;
    ovf = 2'b00;
    setFlag = 2'b00;
    // RULE_13 - split bytes of unit 0
    if (split) begin
      if (enable[0]) begin
        nxt_low[0] = splitLow[7:0];
        ovf[0] = splitLow[8];
      end
      // RULE_20 - high byte uses unit 1 run bit and flag
      if (ctl_ff[`DTCP_CTL_RUN1] && timerTick0) begin
        nxt_high[0] = splitHigh[7:0];
        setFlag[1] = splitHigh[8];
      end
      setFlag[0] = ovf[0];
    end else if (enable[0]) begin
      // RULE_11 - mode selects width
      {ovf[0], nxt_high[0], nxt_low[0]} = step0;
      setFlag[0] = ovf[0];
    end
    // RULE_12 - mode 11 holds unit 1
    if (enable[1] && mode1 != DTCP_SPLIT8) begin
      {ovf[1], nxt_high[1], nxt_low[1]} = step1;
      if (!split) begin
        setFlag[1] = ovf[1];
      end
    end
    // RULE_01 - bytes written separately
    // RULE_09 - write over a running count wins
    if (wrTake) begin
      unique case (idx)
        `DTCP_IDX_LOW0: nxt_low[0] = wByte;
        `DTCP_IDX_LOW1: nxt_low[1] = wByte;
        `DTCP_IDX_HIGH0: nxt_high[0] = wByte;
        `DTCP_IDX_HIGH1: nxt_high[1] = wByte;
        default: ;
      endcase
    end
  end

  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_mode = mode_ff;
    nxt_ckc = ckc_ff;
    nxt_p2 = p2_ff;
    // RULE_15 - isr entry clears flag
    if (isrEnter[1]) begin
      nxt_ctl[`DTCP_CTL_OVF1] = 1'b0;
    end
    if (isrEnter[0]) begin
      nxt_ctl[`DTCP_CTL_OVF0] = 1'b0;
    end
    // RULE_16 - run bits and flags writable
    if (wrTake) begin
      unique case (idx)
        `DTCP_IDX_CONTROL: nxt_ctl = {wByte[7:4], 4'h0};
        `DTCP_IDX_MODE: nxt_mode = wByte;
        `DTCP_IDX_PRESCALE: nxt_ckc = wByte & 8'h18;
        `DTCP_IDX_PORT2: nxt_p2 = wByte & 8'h0c;
        default: ;
      endcase
    end
    // RULE_15 - hardware set wins over clear
    if (setFlag[1]) begin
      nxt_ctl[`DTCP_CTL_OVF1] = 1'b1;
    end
    if (setFlag[0]) begin
      nxt_ctl[`DTCP_CTL_OVF0] = 1'b1;
    end
  end

  logic [1:0] oeBit, oeNext;

  assign oeBit = {p2_ff[`DTCP_P2_OE1], p2_ff[`DTCP_P2_OE0]};
  // next enable, so a disabled pin shows 1 from the very edge it is released
  assign oeNext = {nxt_p2[`DTCP_P2_OE1], nxt_p2[`DTCP_P2_OE0]};

  always_comb begin
    for (int u = 0; u < 2; u++) begin
      nxt_tog[u] = tog_ff[u];
      if (!oeNext[u]) begin
        // RULE_07 - idle at 1 so turn-on shows 1
        nxt_tog[u] = 1'b1;
      end else if (ovf[u]) begin
        // RULE_06 - invert per overflow
        nxt_tog[u] = ~tog_ff[u];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff <= `DTCP_RST_BYTE;
      mode_ff <= `DTCP_RST_BYTE;
      ckc_ff <= `DTCP_RST_BYTE;
      p2_ff <= `DTCP_RST_BYTE;
      low_ff <= '{`DTCP_RST_BYTE, `DTCP_RST_BYTE};
      high_ff <= '{`DTCP_RST_BYTE, `DTCP_RST_BYTE};
      tog_ff <= 2'b11;
    end else begin
      ctl_ff <= nxt_ctl;
      mode_ff <= nxt_mode;
      ckc_ff <= nxt_ckc;
      p2_ff <= nxt_p2;
      low_ff <= nxt_low;
      high_ff <= nxt_high;
      tog_ff <= nxt_tog;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign overflowFlag = {ctl_ff[`DTCP_CTL_OVF1], ctl_ff[`DTCP_CTL_OVF0]};
  // pin driven only with toggle output on; enable is active low
  assign pinsOut.countOut = tog_ff;
  assign pinsOut.countOe_n = ~oeBit;

endmodule

// ==== dv/dtcp_pin_src.sv ====
// pulse source on the count pins, level source on the gate pins
// assumes the bench waits for busy low before asking for the next pulse
`timescale 1ns/1ps
module dtcp_pin_src (
  // clock
  input wire logic clk,
  // bench side
  input wire logic [1:0] pulseGo,
  input wire logic [7:0] halfLen,
  input wire logic [1:0] gateLvl,
  output logic [1:0] busy,
  // device pins
  input wire dtcp_pkg::dtcp_pins_out_s pinsOut,
  output dtcp_pkg::dtcp_pins_in_s pinsIn
);
  import dtcp_pkg::*;
  logic [8:0] cnt [2] = '{9'h000, 9'h000};
  logic [1:0] drv;
  // low then high, each halfLen clocks
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (cnt[i] != 9'h000) cnt[i] <= cnt[i] - 9'h001;
      else if (pulseGo[i]) cnt[i] <= {halfLen, 1'b0};
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      busy[i] = cnt[i] != 9'h000;
      drv[i] = cnt[i] <= {1'b0, halfLen};
    end
  end
  // device wins the shared pin while its enable is low
  assign pinsIn.countPin = (drv & pinsOut.countOe_n) | (pinsOut.countOut & ~pinsOut.countOe_n);
  // gate level straight from the bench
  assign pinsIn.gatePin = gateLvl;
endmodule

// ==== dv/dtcp_timer_pair_asserts.sv ====
// port checker for the timer pair: bus handshake, flags, toggle output
// assumes one clock domain; bound into every dtcp_timer_pair instance
`timescale 1ns/1ps
module dtcp_timer_pair_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // flags and pins
  input wire logic [1:0] isrEnter,
  input wire logic [1:0] overflowFlag,
  input wire dtcp_pkg::dtcp_pins_out_s pinsOut
);
  import dtcp_pkg::*;
  // --------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rst_vals;
    $rose(rst_n) |-> overflowFlag == 2'h0 && pinsOut.countOut == 2'h3;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs wrong after reset");
  property p_wait_one;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("more than one wait state");
  property p_wait_idle;
    !(read || write) |-> !waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest without request");
  property p_rd_upper;
    read && !waitrequest |-> readdata[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("readdata upper bits not zero");
  // flags are sticky: only an entry pulse or a bus write drops them
  property p_flag_hold0;
    overflowFlag[0] && !isrEnter[0] && !(write && !waitrequest) |=> overflowFlag[0];
  endproperty
  a_flag_hold0: assert property (p_flag_hold0)
    else $error("unit 0 flag dropped by itself");
  property p_flag_hold1;
    overflowFlag[1] && !isrEnter[1] && !(write && !waitrequest) |=> overflowFlag[1];
  endproperty
  a_flag_hold1: assert property (p_flag_hold1)
    else $error("unit 1 flag dropped by itself");
  property p_tog_rise;
    $rose(overflowFlag[0]) && !pinsOut.countOe_n[0] && !$past(pinsOut.countOe_n[0])
      && !$past(write) |-> $changed(pinsOut.countOut[0]);
  endproperty
  a_tog_rise: assert property (p_tog_rise)
    else $error("overflow without toggle");
  property p_tog_cause;
    $changed(pinsOut.countOut[0]) && !pinsOut.countOe_n[0]
      && !$past(pinsOut.countOe_n[0]) |-> overflowFlag[0];
  endproperty
  a_tog_cause: assert property (p_tog_cause)
    else $error("toggle without overflow");
  property p_tog_dis;
    (pinsOut.countOut | ~pinsOut.countOe_n) == 2'h3;
  endproperty
  a_tog_dis: assert property (p_tog_dis)
    else $error("disabled toggle output not high");
  c_read: cover property (read && !waitrequest);
  c_flag: cover property ($rose(overflowFlag[1]));
  c_tog: cover property ($changed(pinsOut.countOut[0]));
endmodule

bind dtcp_timer_pair dtcp_timer_pair_asserts u_asserts (
  .clk(clk), .rst_n(rst_n), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .isrEnter(isrEnter), .overflowFlag(overflowFlag),
  .pinsOut(pinsOut));

// ==== dv/dtcp_timer_pair_tb.sv ====
// bench for the timer pair: registers, count modes, gate, flags, toggle output
// assumes the pin source model and the bound checker are compiled alongside
`timescale 1ns/1ps
`include "dtcp_map.svh"
module dtcp_timer_pair_tb;
  import dtcp_pkg::*;
  localparam int DIV = 4;
  // unit, mode, high, low, gate level, expected high, low, flag
  localparam dtcp_byte_t CASES [9][8] = '{
    '{8'h00, 8'h04, 8'hff, 8'hfe, 8'h01, 8'h00, 8'he1, 8'h01},
    '{8'h00, 8'h05, 8'hff, 8'hfe, 8'h01, 8'h00, 8'h01, 8'h01},
    '{8'h00, 8'h06, 8'h80, 8'hfe, 8'h01, 8'h80, 8'h81, 8'h01},
    '{8'h00, 8'h0d, 8'hff, 8'hfe, 8'h00, 8'hff, 8'hfe, 8'h00},
    '{8'h00, 8'h0d, 8'h12, 8'h34, 8'h01, 8'h12, 8'h37, 8'h00},
    '{8'h01, 8'h50, 8'hff, 8'hfe, 8'h01, 8'h00, 8'h01, 8'h01},
    '{8'h01, 8'h70, 8'hff, 8'hfe, 8'h01, 8'hff, 8'hfe, 8'h00},
    '{8'h01, 8'h60, 8'hfe, 8'hfe, 8'h01, 8'hfe, 8'hff, 8'h01},
    '{8'h00, 8'h07, 8'h55, 8'hfe, 8'h01, 8'h55, 8'h01, 8'h01}};
  localparam dtcp_byte_t IDX [7] = '{`DTCP_IDX_CONTROL, `DTCP_IDX_MODE, `DTCP_IDX_LOW0,
    `DTCP_IDX_LOW1, `DTCP_IDX_HIGH0, `DTCP_IDX_HIGH1, 8'h00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] isrEnter = 2'h0;
  logic [1:0] overflowFlag;
  logic [1:0] pulseGo = 2'h0;
  logic [7:0] halfLen = 8'h02;
  logic [1:0] gateLvl = 2'h3;
  logic [1:0] busy;
  dtcp_pins_in_s pinsIn;
  dtcp_pins_out_s pinsOut;
  dtcp_byte_t expQ [$];
  dtcp_byte_t v;
  dtcp_byte_t run;
  dtcp_byte_t per;
  int nMismatch = 0;
  int checksDone = 0;
  int seed = 32'h27f3_faf7;
  int u;

  initial begin
    forever #5 clk = ~clk;
  end

  dtcp_timer_pair #(.PRESCALE_DIV(DIV)) dut (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .isrEnter(isrEnter),
    .overflowFlag(overflowFlag), .pinsIn(pinsIn), .pinsOut(pinsOut));
  dtcp_pin_src u_src (.clk(clk), .pulseGo(pulseGo), .halfLen(halfLen), .gateLvl(gateLvl),
    .busy(busy), .pinsOut(pinsOut), .pinsIn(pinsIn));

  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task stop_test;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input dtcp_byte_t e, input dtcp_byte_t g);
    checksDone++;
    if (g !== e) begin
      nMismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // request held until waitrequest is sampled low
  task bus(input logic wr, input dtcp_byte_t idx, input dtcp_byte_t d);
    int n;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= {idx, 2'h0};
    writedata <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (waitrequest !== 1'b0) nMismatch++;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task rd(input dtcp_byte_t idx, input dtcp_byte_t e);
    expQ.push_back(e);
    bus(1'b0, idx, 8'h00);
  endtask

  task pulses(input int p, input int n);
    int k;
    repeat (n) begin
      @(posedge clk);
      pulseGo[p] <= 1'b1;
      @(posedge clk);
      pulseGo[p] <= 1'b0;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (busy[p] === 1'b1 && k < 600);
    end
    repeat (6) @(posedge clk);
  endtask

  // second interval only: the first may straddle a clock switch
  task period(output dtcp_byte_t p);
    logic lvl;
    repeat (2) begin
      lvl = pinsOut.countOut[0];
      p = 8'h00;
      do begin
        @(posedge clk);
        p++;
      end while (pinsOut.countOut[0] === lvl && p < 8'h64);
    end
  endtask

  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) chk("readdata", expQ.pop_front(), readdata[7:0]);
  end

  initial begin
    #300000;
    nMismatch++;
    stop_test;
  end

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd(IDX[i], 8'h00);
    for (int i = 2; i < 6; i++) begin
      v = $random(seed);
      bus(1'b1, IDX[i], v);
      rd(IDX[i], v);
    end
    bus(1'b1, 8'h00, 8'h5a);
    rd(8'h00, 8'h00);
    bus(1'b1, `DTCP_IDX_CONTROL, 8'h0f);
    rd(`DTCP_IDX_CONTROL, 8'h00);
    $display("test registers done");
    for (int c = 0; c < 9; c++) begin
      u = CASES[c][0][0];
      run = u ? 8'h40 : 8'h10;
      halfLen <= halfLen + 8'h01;
      gateLvl <= {2{CASES[c][4][0]}};
      bus(1'b1, `DTCP_IDX_MODE, CASES[c][1]);
      bus(1'b1, u ? `DTCP_IDX_HIGH1 : `DTCP_IDX_HIGH0, CASES[c][2]);
      bus(1'b1, u ? `DTCP_IDX_LOW1 : `DTCP_IDX_LOW0, CASES[c][3]);
      bus(1'b1, `DTCP_IDX_CONTROL, run);
      pulses(u, 3);
      chk("overflowFlag", CASES[c][7], {7'h00, overflowFlag[u]});
      rd(`DTCP_IDX_CONTROL, run | (CASES[c][7][0] ? run << 1 : 8'h00));
      @(posedge clk);
      isrEnter[u] <= 1'b1;
      @(posedge clk);
      isrEnter[u] <= 1'b0;
      @(posedge clk);
      chk("overflowFlag", 8'h00, {7'h00, overflowFlag[u]});
      bus(1'b1, `DTCP_IDX_CONTROL, 8'h00);
      rd(u ? `DTCP_IDX_HIGH1 : `DTCP_IDX_HIGH0, CASES[c][5]);
      rd(u ? `DTCP_IDX_LOW1 : `DTCP_IDX_LOW0, CASES[c][6]);
      $display("test count case %0d done", c);
    end
    bus(1'b1, `DTCP_IDX_MODE, 8'h02);
    bus(1'b1, `DTCP_IDX_HIGH0, 8'hff);
    bus(1'b1, `DTCP_IDX_LOW0, 8'hff);
    bus(1'b1, `DTCP_IDX_PORT2, 8'h04);
    // let the landed write settle before looking at the pins
    @(posedge clk);
    chk("countOe_n", 8'h02, {6'h00, pinsOut.countOe_n});
    chk("countOut", 8'h03, {6'h00, pinsOut.countOut});
    bus(1'b1, `DTCP_IDX_CONTROL, 8'h10);
    for (int k = 0; k < 100 && overflowFlag[0] !== 1'b1; k++) @(posedge clk);
    chk("countOut", 8'h02, {6'h00, pinsOut.countOut});
    for (int b = 0; b < 2; b++) begin
      bus(1'b1, `DTCP_IDX_PRESCALE, b ? 8'h08 : 8'h00);
      period(per);
      chk("period", b ? 8'h01 : 8'(DIV), per);
    end
    bus(1'b1, `DTCP_IDX_PORT2, 8'h00);
    @(posedge clk);
    chk("countOut", 8'h03, {6'h00, pinsOut.countOut});
    bus(1'b1, `DTCP_IDX_CONTROL, 8'h00);
    $display("test toggle done");
    repeat (4) @(posedge clk);
    stop_test;
  end
endmodule
